// *** core/ecio_core.sv ***
// Decided for this implementation: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
// Functional notes
// - Sample every external control input once per 2 ms detection period.
// - Ignore external control inputs unless external control enable is set.
// - Refresh the external status lines every 0.1 ms.
// - Power status line is low when power is off, high when on.
// - Output status line is low when output off, high when on.
// - Overload status line is high only while an overload exists.
// - Busy status line is high while internal processing is busy.
// - Two lines carry bit 0 and bit 1 of the current step sync code.
// - A falling edge on output-off switches the output off.
// - A falling edge on output-on switches the output on.
// - A falling edge on sequence start starts the sequence.
// - A falling edge on sequence stop stops the sequence.
// - A falling edge on sequence hold pauses the running sequence.
// - Branch trigger zero jumps to the current step's branch-zero target.
// - Branch trigger one jumps to the current step's branch-one target.
// - Thirty settings slots support store, recall and clear.
// - Store and recall are refused while the output is on.
// - Settings survive a power cycle; response selection does not.
// - REN enters remote mode and GTL returns to local mode.
// - Local key leaves remote mode unless local lockout or keylock.
// - Front-panel output-off key works in every mode.
module ecio_core #(
    parameter int DETECT_CYCLES = ecio_pkg::DETECT_CYCLES_DEF,
    parameter int REFRESH_CYCLES = ecio_pkg::REFRESH_CYCLES_DEF
) (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic bkup_rst_n_i,
    input wire logic [5:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire ecio_pkg::ecio_input_type ext_ctrl_i,
    output ecio_pkg::ecio_status_type ext_status_o,
    input wire logic power_good_i,
    input wire logic overload_i,
    input wire logic busy_i,
    input wire logic ifc_ren_i,
    input wire logic ifc_gtl_i,
    input wire logic ifc_llo_i,
    input wire logic panel_local_key_i,
    input wire logic panel_output_off_key_i,
    output logic output_on_o,
    output logic remote_indicator_o,
    output logic [31:0] settings_o,
    output logic [31:0] response_o
);
    import ecio_pkg::*;

    function automatic logic [31:0] merge_be(input logic [31:0] old_val,
                                             input logic [31:0] new_val,
                                             input logic [3:0] be);
        logic [31:0] res;
        res = old_val;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = new_val[i*8 +: 8];
            end
        end
        return res;
    endfunction : merge_be

    // Bus slave: every access answers on the second edge after it rises.
    logic ack;
    logic bus_req;
    logic wr_en;
    logic [31:0] rd_mux;
    assign bus_req = avs_read_i | avs_write_i;
    assign avs_waitrequest_o = bus_req & ~ack;
    assign wr_en = avs_write_i & ack;

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            ack <= 1'b0;
        end else begin
            ack <= bus_req & ~ack;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            avs_readdata_o <= 32'h0000_0000;
        end else if (avs_read_i & ~ack) begin
            avs_readdata_o <= rd_mux;
        end
    end

    // Control register and one-cycle command pulses.
    logic ext_enable;
    logic keylock;
    logic [6:0] cmd_pulse;
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            ext_enable <= 1'b0;
            keylock <= 1'b0;
        end else if (wr_en && avs_address_i == REG_CTRL &&
                     avs_byteenable_i[0]) begin
            ext_enable <= avs_writedata_i[CTRL_EXT_EN_BIT];
            keylock <= avs_writedata_i[CTRL_KEYLOCK_BIT];
        end
    end
    assign cmd_pulse = (wr_en && avs_address_i == REG_CMD &&
                        avs_byteenable_i[0]) ?
                       avs_writedata_i[6:0] : 7'h00;

    // Input synchroniser and detection sampling.
    ecio_input_type sync1;
    ecio_input_type sync2;
    ecio_input_type sample;
    ecio_input_type fall;
    ecio_input_type ext_act;
    logic [$clog2(DETECT_CYCLES+1)-1:0] detect_cnt;
    logic detect_tick;
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            sync1 <= INPUT_IDLE;
            sync2 <= INPUT_IDLE;
        end else begin
            sync1 <= ext_ctrl_i;
            sync2 <= sync1;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i || detect_tick) begin
            detect_cnt <= '0;
        end else begin
            detect_cnt <= detect_cnt + 1'b1;
        end
    end
    assign detect_tick = (detect_cnt == DETECT_CYCLES - 1);

    // A line is only compared between detection instants, so glitches
    // shorter than the period are filtered out or missed by design.
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            sample <= INPUT_IDLE;
            fall <= '0;
        end else if (detect_tick) begin
            sample <= sync2;
            fall <= sample & ~sync2;
        end else begin
            fall <= '0;
        end
    end
    assign ext_act = ext_enable ? fall : '0;

    // Output state; any off request wins over any on request.
    logic output_on;
    logic off_req;
    logic on_req;
    assign off_req = ext_act.out_off | cmd_pulse[CMD_OUT_OFF_BIT] |
                     panel_output_off_key_i;
    assign on_req = ext_act.out_on | cmd_pulse[CMD_OUT_ON_BIT];
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            output_on <= 1'b0;
        end else if (off_req) begin
            output_on <= 1'b0;
        end else if (on_req) begin
            output_on <= 1'b1;
        end
    end
    assign output_on_o = output_on;

    // Sequence control and step pointer.
    ecio_seq_type seq_state;
    ecio_seq_type next_seq_state;
    logic [STEP_W-1:0] cur_step;
    logic [STEP_W-1:0] step_sel;
    ecio_step_type step_table [STEP_COUNT];
    ecio_step_type cur_entry;
    logic do_start;
    logic do_stop;
    logic do_hold;
    assign cur_entry = step_table[cur_step];
    assign do_start = ext_act.seq_start | cmd_pulse[CMD_START_BIT];
    assign do_stop = ext_act.seq_stop | cmd_pulse[CMD_STOP_BIT];
    assign do_hold = ext_act.seq_hold | cmd_pulse[CMD_HOLD_BIT];

    always_comb begin
        next_seq_state = seq_state;
        case (seq_state)
            SEQ_IDLE: begin
                if (do_start && !do_stop) begin
                    next_seq_state = SEQ_RUN;
                end
            end
            SEQ_RUN: begin
                if (do_stop) begin
                    next_seq_state = SEQ_IDLE;
                end else if (do_hold) begin
                    next_seq_state = SEQ_HOLD;
                end
            end
            SEQ_HOLD: begin
                if (do_stop) begin
                    next_seq_state = SEQ_IDLE;
                end else if (do_start) begin
                    next_seq_state = SEQ_RUN;
                end
            end
            default: begin
                next_seq_state = SEQ_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            seq_state <= SEQ_IDLE;
        end else begin
            seq_state <= next_seq_state;
        end
    end

    // Branches act only on an active sequence; zero wins if both fire.
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            cur_step <= '0;
        end else if (seq_state != SEQ_IDLE && ext_act.branch_zero) begin
            cur_step <= cur_entry.branch_target_zero;
        end else if (seq_state != SEQ_IDLE && ext_act.branch_one) begin
            cur_step <= cur_entry.branch_target_one;
        end else if (wr_en && avs_address_i == REG_STEP) begin
            cur_step <= avs_writedata_i[STEP_W-1:0];
        end
    end

    // Backed-up storage clears only on battery loss, not on power cycle.
    logic [31:0] settings;
    logic [31:0] slots [SLOT_COUNT];
    logic [31:0] response;
    logic mem_refused;
    logic mem_req;
    logic mem_bad;
    ecio_mem_op_type mem_op;
    logic [4:0] mem_slot;
    logic [4:0] mem_idx;
    assign mem_req = wr_en && avs_address_i == REG_MEMCMD;
    assign mem_op = ecio_mem_op_type'(avs_writedata_i[MEMCMD_OP_LSB +: 2]);
    assign mem_slot = avs_writedata_i[4:0];
    assign mem_idx = mem_slot - 5'h01;
    assign mem_bad = mem_slot == 5'h00 || mem_slot > 5'(SLOT_COUNT) ||
                     (output_on && mem_op != MEM_CLEAR);

    always_ff @(posedge core_clk_i) begin
        if (!bkup_rst_n_i) begin
            settings <= SETTINGS_INIT;
            for (int i = 0; i < SLOT_COUNT; i++) begin
                slots[i] <= SETTINGS_INIT;
            end
        end else if (mem_req && !mem_bad) begin
            case (mem_op)
                MEM_STORE: slots[mem_idx] <= settings;
                MEM_RECALL: settings <= slots[mem_idx];
                MEM_CLEAR: slots[mem_idx] <= SETTINGS_INIT;
                default: begin
                end
            endcase
        end else if (wr_en && avs_address_i == REG_SETTINGS) begin
            settings <= merge_be(settings, avs_writedata_i,
                                 avs_byteenable_i);
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!bkup_rst_n_i) begin
            step_sel <= '0;
            for (int i = 0; i < STEP_COUNT; i++) begin
                step_table[i] <= STEP_ENTRY_INIT;
            end
        end else if (wr_en && avs_address_i == REG_STEP_SEL) begin
            step_sel <= avs_writedata_i[STEP_W-1:0];
        end else if (wr_en && avs_address_i == REG_STEP_DATA) begin
            step_table[step_sel] <= avs_writedata_i[17:0];
        end
    end

    // Response selection is volatile and returns to default on power-up.
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            response <= RESPONSE_INIT;
        end else if (wr_en && avs_address_i == REG_RESPONSE) begin
            response <= merge_be(response, avs_writedata_i, avs_byteenable_i);
        end
    end
    assign settings_o = settings;
    assign response_o = response;

    // Refusal flag: a new refusal wins over a write-one clear.
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            mem_refused <= 1'b0;
        end else if (mem_req && mem_bad && mem_op != MEM_NOP) begin
            mem_refused <= 1'b1;
        end else if (wr_en && avs_address_i == REG_STATUS &&
                     avs_writedata_i[STAT_REFUSED_BIT]) begin
            mem_refused <= 1'b0;
        end
    end

    // Operating mode.
    ecio_mode_type mode;
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            mode <= MODE_LOCAL;
        end else if (ifc_gtl_i) begin
            mode <= MODE_LOCAL;
        end else if (ifc_llo_i) begin
            mode <= MODE_LOCKOUT;
        end else if (ifc_ren_i && mode == MODE_LOCAL) begin
            mode <= MODE_REMOTE;
        end else if (panel_local_key_i && mode == MODE_REMOTE &&
                     !keylock) begin
            mode <= MODE_LOCAL;
        end
    end
    assign remote_indicator_o = (mode != MODE_LOCAL);

    // Status lines refresh on their own tick.
    logic [$clog2(REFRESH_CYCLES+1)-1:0] refresh_cnt;
    logic refresh_tick;
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i || refresh_tick) begin
            refresh_cnt <= '0;
        end else begin
            refresh_cnt <= refresh_cnt + 1'b1;
        end
    end
    assign refresh_tick = (refresh_cnt == REFRESH_CYCLES - 1);

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            ext_status_o <= '0;
        end else if (refresh_tick) begin
            ext_status_o.power_on <= power_good_i;
            ext_status_o.output_on <= output_on;
            ext_status_o.overload <= overload_i;
            ext_status_o.busy <= busy_i;
            ext_status_o.step_sync <= cur_entry.step_sync;
        end
    end

    always_comb begin
        rd_mux = 32'h0000_0000;
        case (avs_address_i)
            REG_CTRL: rd_mux = {30'h0, keylock, ext_enable};
            REG_STATUS: rd_mux = {26'h0, mem_refused, mode, seq_state,
                                  output_on};
            REG_STEP: rd_mux = {27'h0, cur_step};
            REG_SETTINGS: rd_mux = settings;
            REG_RESPONSE: rd_mux = response;
            REG_STEP_SEL: rd_mux = {27'h0, step_sel};
            REG_STEP_DATA: rd_mux = {14'h0, step_table[step_sel]};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);

    a_detect_bound: assert property (detect_cnt < DETECT_CYCLES)
        else $error("Detection counter out of range.");
    a_ignore_disabled: assert property (!ext_enable |-> ext_act == '0)
        else $error("External input acted while disabled.");
    a_status_refresh: assert property (refresh_tick |=>
        ext_status_o.output_on == $past(output_on))
        else $error("Status line not refreshed.");
    a_power_line: assert property (refresh_tick |=>
        ext_status_o.power_on == $past(power_good_i))
        else $error("Power status line wrong.");
    a_edge_once: assert property (fall != '0 |=> fall == '0)
        else $error("Edge acted on twice.");
    a_output_off: assert property (off_req |=> !output_on)
        else $error("Output not switched off.");
    a_output_on: assert property (ext_act.out_on && !off_req |=>
        output_on)
        else $error("Output not switched on.");
    a_seq_stop: assert property (do_stop |=> seq_state == SEQ_IDLE)
        else $error("Sequence did not stop.");
    a_seq_start: assert property (do_start && !do_stop &&
        seq_state != SEQ_RUN |=> seq_state == SEQ_RUN)
        else $error("Sequence did not start.");
    a_branch_zero: assert property (seq_state != SEQ_IDLE &&
        ext_act.branch_zero |=> cur_step == $past(cur_entry.branch_target_zero))
        else $error("Branch zero target not taken.");
    a_mem_refuse: assert property (mem_req && output_on &&
        mem_op == MEM_RECALL |=> settings == $past(settings) && mem_refused)
        else $error("Recall accepted with output on.");
    a_lockout_hold: assert property (mode == MODE_LOCKOUT &&
        !ifc_gtl_i |=> mode == MODE_LOCKOUT)
        else $error("Lockout left without GTL.");

    c_ext_on: cover property (ext_act.out_on ##1 output_on);
    c_branch: cover property (seq_state == SEQ_RUN && ext_act.branch_one);
    c_refused: cover property (mem_req && mem_bad ##1 mem_refused);
    c_local_key: cover property (mode == MODE_REMOTE && panel_local_key_i);
endmodule : ecio_core

// *** shared/ecio_pkg.sv ***
package ecio_pkg;
    // Clock and timing figures.
    localparam int CLK_PERIOD_PS = 4000;
    localparam longint DETECT_PERIOD_NS = 2000000;
    localparam longint REFRESH_PERIOD_NS = 100000;
    localparam int DETECT_CYCLES_DEF =
        int'((DETECT_PERIOD_NS * 1000) / CLK_PERIOD_PS);
    localparam int REFRESH_CYCLES_DEF =
        int'((REFRESH_PERIOD_NS * 1000) / CLK_PERIOD_PS);
    // Register byte addresses.
    localparam logic [5:0] REG_CTRL = 6'h00;
    localparam logic [5:0] REG_CMD = 6'h04;
    localparam logic [5:0] REG_STATUS = 6'h08;
    localparam logic [5:0] REG_STEP = 6'h0C;
    localparam logic [5:0] REG_SETTINGS = 6'h10;
    localparam logic [5:0] REG_RESPONSE = 6'h14;
    localparam logic [5:0] REG_MEMCMD = 6'h18;
    localparam logic [5:0] REG_STEP_SEL = 6'h1C;
    localparam logic [5:0] REG_STEP_DATA = 6'h20;
    // Field positions.
    localparam int CTRL_EXT_EN_BIT = 0;
    localparam int CTRL_KEYLOCK_BIT = 1;
    localparam int CMD_OUT_ON_BIT = 0;
    localparam int CMD_OUT_OFF_BIT = 1;
    localparam int CMD_START_BIT = 2;
    localparam int CMD_STOP_BIT = 3;
    localparam int CMD_HOLD_BIT = 4;
    localparam int STAT_REFUSED_BIT = 5;
    localparam int MEMCMD_OP_LSB = 8;
    // Sizes and reset values.
    localparam int STEP_W = 5;
    localparam int STEP_COUNT = 32;
    localparam int SLOT_COUNT = 30;
    localparam logic [31:0] SETTINGS_INIT = 32'h0000_0000;
    localparam logic [31:0] RESPONSE_INIT = 32'h0000_0000;
    localparam logic [17:0] STEP_ENTRY_INIT = 18'h0_0000;
    localparam logic [6:0] INPUT_IDLE = 7'h7F;

    typedef enum logic [1:0] {
        MEM_NOP = 2'b00,
        MEM_STORE = 2'b01,
        MEM_RECALL = 2'b10,
        MEM_CLEAR = 2'b11
    } ecio_mem_op_type;

    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_RUN = 2'b01,
        SEQ_HOLD = 2'b10
    } ecio_seq_type;

    typedef enum logic [1:0] {
        MODE_LOCAL = 2'b00,
        MODE_REMOTE = 2'b01,
        MODE_LOCKOUT = 2'b10
    } ecio_mode_type;

    // Control lines, all idle high, acting on the falling edge.
    typedef struct packed {
        logic branch_one;
        logic branch_zero;
        logic seq_hold;
        logic seq_stop;
        logic seq_start;
        logic out_on;
        logic out_off;
    } ecio_input_type;

    typedef struct packed {
        logic [1:0] step_sync;
        logic busy;
        logic overload;
        logic output_on;
        logic power_on;
    } ecio_status_type;

    typedef struct packed {
        logic [1:0] step_sync;
        logic [2:0] spare;
        logic [STEP_W-1:0] branch_target_one;
        logic [2:0] pad;
        logic [STEP_W-1:0] branch_target_zero;
    } ecio_step_type;
endpackage : ecio_pkg

// *** testbench/ecio_ext_model.sv ***
`timescale 1ns/1ps
module ecio_ext_model #(
    parameter int DETECT_CYCLES = 20
) (
    input wire logic core_clk_i,
    input wire logic fire_i,
    input wire logic [2:0] line_i,
    output logic done_o,
    output ecio_pkg::ecio_input_type ext_ctrl_o
);
    import ecio_pkg::*;
    int cnt = 0;
    initial begin
        ext_ctrl_o = INPUT_IDLE;
        done_o = 1'b0;
    end
    // Lines have pull-ups, so a released line reads high.
    // Low for three periods so that three detection instants see it low.
    always @(posedge core_clk_i) begin
        done_o <= 1'b0;
        if (fire_i && cnt == 0) begin
            ext_ctrl_o[line_i] <= 1'b0;
            cnt <= 5 * DETECT_CYCLES;
        end else if (cnt == 2 * DETECT_CYCLES) begin
            ext_ctrl_o <= INPUT_IDLE;
            cnt <= cnt - 1;
        end else if (cnt == 1) begin
            done_o <= 1'b1;
            cnt <= 0;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
        end
    end
endmodule : ecio_ext_model

// *** testbench/external_control_io_logic_tb_top.sv ***
`timescale 1ns/1ps
module external_control_io_logic_tb_top;
    import ecio_pkg::*;
    localparam int DET = 20;
    localparam int REF = 5;
    logic core_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic bkup_rst_n_i = 1'b0;
    logic [5:0] avs_address_i = 6'h00;
    logic avs_read_i = 1'b0;
    logic avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0000_0000;
    logic [31:0] avs_readdata_o;
    logic avs_waitrequest_o;
    logic [4:0] msg = 5'h00;
    logic [2:0] pwr = 3'h0;
    logic fire = 1'b0;
    logic [2:0] line = 3'h0;
    logic done;
    ecio_input_type ext_ctrl_i;
    ecio_status_type ext_status_o;
    logic output_on_o;
    logic remote_indicator_o;
    logic [31:0] settings_o;
    logic [31:0] response_o;
    int failures = 0;
    int samples_checked = 0;
    always #2 core_clk_i = ~core_clk_i;
    ecio_core #(.DETECT_CYCLES(DET), .REFRESH_CYCLES(REF)) ecio_core_inst (
        .core_clk_i, .rst_n_i, .bkup_rst_n_i, .avs_address_i, .avs_read_i,
        .avs_write_i, .avs_writedata_i, .avs_byteenable_i(4'hF),
        .avs_readdata_o, .avs_waitrequest_o, .ext_ctrl_i, .ext_status_o,
        .power_good_i(pwr[0]), .overload_i(pwr[1]), .busy_i(pwr[2]),
        .ifc_ren_i(msg[0]), .ifc_gtl_i(msg[1]), .ifc_llo_i(msg[2]),
        .panel_local_key_i(msg[3]), .panel_output_off_key_i(msg[4]),
        .output_on_o, .remote_indicator_o, .settings_o, .response_o);
    ecio_ext_model #(.DETECT_CYCLES(DET)) ecio_ext_model_inst (
        .core_clk_i, .fire_i(fire), .line_i(line), .done_o(done),
        .ext_ctrl_o(ext_ctrl_i));
    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : summarize
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %s expected %0h seen %0h", nm, e, g);
        end
    endtask : chk
    // Holds the request until waitrequest is seen low at a rising edge.
    task automatic bus(input logic w, input logic [5:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge core_clk_i);
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_write_i <= w;
        avs_read_i <= !w;
        do begin
            @(posedge core_clk_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0 && n < 100);
        q = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
        if (n >= 100) begin
            failures++;
            summarize();
        end
    endtask : bus
    // Waits to the falling edge so that outputs written at the final
    // edge have settled before any caller compares them.
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
        @(negedge core_clk_i);
    endtask : wr
    task automatic rdchk(input logic [5:0] a, input logic [31:0] e,
                         input string nm);
        logic [31:0] q;
        bus(1'b0, a, 32'h0000_0000, q);
        chk(nm, e, q);
    endtask : rdchk
    task automatic ext(input logic [2:0] i);
        int n;
        n = 0;
        @(posedge core_clk_i);
        fire <= 1'b1;
        line <= i;
        @(posedge core_clk_i);
        fire <= 1'b0;
        while (done !== 1'b1 && n < 8 * DET) begin
            @(posedge core_clk_i);
            n++;
        end
        if (n >= 8 * DET) begin
            failures++;
            summarize();
        end
    endtask : ext
    task automatic ping(input int i);
        @(posedge core_clk_i);
        msg <= 5'(1 << i);
        @(posedge core_clk_i);
        msg <= 5'h00;
    endtask : ping
    task automatic settle();
        repeat (2 * REF + 2) @(posedge core_clk_i);
    endtask : settle
    initial begin
        repeat (8) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        bkup_rst_n_i <= 1'b1;
        ext(3'h1);
        chk("out_off_dis", 32'h0, {31'h0, output_on_o});
        wr(REG_CTRL, 32'h0000_0001);
        ext(3'h1);
        chk("out_on", 32'h1, {31'h0, output_on_o});
        pwr <= 3'h7;
        settle();
        chk("st_hi", 32'hF, 32'(ext_status_o));
        pwr <= 3'h0;
        settle();
        chk("status_lo", 32'h2, 32'(ext_status_o));
        wr(REG_MEMCMD, 32'h0000_0101);
        rdchk(REG_STATUS, 32'h21, "store_on");
        wr(REG_STATUS, 32'h0000_0020);
        wr(REG_SETTINGS, 32'h0000_0055);
        wr(REG_MEMCMD, 32'h0000_0201);
        chk("recall_on", 32'h0000_0055, settings_o);
        rdchk(REG_STATUS, 32'h21, "recall_flag");
        wr(REG_STATUS, 32'h0000_0020);
        wr(REG_MEMCMD, 32'h0000_0001);
        rdchk(REG_STATUS, 32'h01, "mem_nop");
        ext(3'h0);
        chk("out_off", 32'h0, {31'h0, output_on_o});
        wr(REG_CMD, 32'h0000_0001);
        chk("cmd_on", 32'h1, {31'h0, output_on_o});
        wr(REG_CMD, 32'h0000_0002);
        chk("cmd_off", 32'h0, {31'h0, output_on_o});
        wr(REG_SETTINGS, 32'hA5C3_1E0F);
        wr(REG_MEMCMD, 32'h0000_011E);
        wr(REG_SETTINGS, 32'h0000_0000);
        wr(REG_MEMCMD, 32'h0000_021E);
        chk("recall", 32'hA5C3_1E0F, settings_o);
        wr(REG_MEMCMD, 32'h0000_031E);
        wr(REG_MEMCMD, 32'h0000_021E);
        chk("cleared", SETTINGS_INIT, settings_o);
        rdchk(REG_STATUS, 32'h00, "mem_ok");
        wr(REG_MEMCMD, 32'h0000_011F);
        rdchk(REG_STATUS, 32'h20, "bad_slot");
        wr(REG_STATUS, 32'h0000_0020);
        ext(3'h2);
        rdchk(REG_STATUS, 32'h02, "seq_run");
        ext(3'h4);
        rdchk(REG_STATUS, 32'h04, "seq_hold");
        ext(3'h3);
        rdchk(REG_STATUS, 32'h00, "seq_stop");
        wr(REG_STEP_SEL, 32'h0000_0000);
        wr(REG_STEP_DATA, 32'h0002_0905);
        wr(REG_STEP_SEL, 32'h0000_0005);
        wr(REG_STEP_DATA, 32'h0001_0300);
        wr(REG_CMD, 32'h0000_0004);
        rdchk(REG_STATUS, 32'h02, "cmd_start");
        settle();
        chk("sync_a", 32'h2, 32'(ext_status_o.step_sync));
        ext(3'h5);
        rdchk(REG_STEP, 32'h05, "branch_zero");
        settle();
        chk("sync_b", 32'h1, 32'(ext_status_o.step_sync));
        ext(3'h6);
        rdchk(REG_STEP, 32'h03, "branch_one");
        wr(REG_CMD, 32'h0000_0008);
        rdchk(REG_STATUS, 32'h00, "cmd_stop");
        ext(3'h1);
        ping(0);
        rdchk(REG_STATUS, 32'h09, "remote");
        chk("rmt_ind", 32'h1, {31'h0, remote_indicator_o});
        ping(3);
        rdchk(REG_STATUS, 32'h01, "local_key");
        ping(0);
        ping(2);
        ping(3);
        rdchk(REG_STATUS, 32'h11, "lockout");
        ping(4);
        rdchk(REG_STATUS, 32'h10, "off_key");
        ping(1);
        rdchk(REG_STATUS, 32'h00, "gtl");
        chk("rmt_off", 32'h0, {31'h0, remote_indicator_o});
        wr(REG_CTRL, 32'h0000_0003);
        ping(0);
        ping(3);
        rdchk(REG_STATUS, 32'h08, "keylock");
        rdchk(6'h3C, 32'h0, "unmapped");
        wr(REG_SETTINGS, 32'h0000_BEEF);
        wr(REG_RESPONSE, 32'h0000_0007);
        chk("resp_set", 32'h0000_0007, response_o);
        @(posedge core_clk_i);
        rst_n_i <= 1'b0;
        repeat (2) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        @(posedge core_clk_i);
        chk("kept", 32'h0000_BEEF, settings_o);
        chk("resp_lost", RESPONSE_INIT, response_o);
        rdchk(REG_STATUS, 32'h00, "mode_rst");
        summarize();
    end
endmodule : external_control_io_logic_tb_top
